//--- hdl/tdio_pkg.sv
// Shared constants for the test data I/O subsystems block
package tdio_pkg;
	// Clock and time base
	localparam int CLK_NS = 100;
	localparam int TB_NS = 1000;
	localparam int US_CYC = TB_NS / CLK_NS;
	localparam int MS_US = 1000;
	localparam int PPS_MS = 1000;
	// Watchdog limit, 10 ms, rounded down
	localparam int WDOG_NS = 10_000_000;
	localparam int WDOG_CYC = WDOG_NS / CLK_NS;
	// Conversion pacing, 10,000 per second gives 100 us, rounded up
	localparam int CONV_NS = 100_000;
	localparam int CONV_CYC = (CONV_NS + CLK_NS - 1) / CLK_NS;
	// Display conversion budget
	localparam int DISP_NS = 100_000;
	localparam int DISP_CYC = DISP_NS / CLK_NS;
	// Geometry
	localparam int LL_GROUPS = 4;
	localparam int LL_CHANS = 96;
	localparam int HL_CHANS = 128;
	localparam int MAG_W = 14;
	localparam int TIME_W = 24;
	localparam int RELAYS = 24;
	localparam int EV_GROUPS = 3;
	localparam int EV_W = 24;
	localparam int DISPS = 4;
	localparam int DMAG_W = 10;
	localparam logic [9:0] DISP_MAX = 10'h3E7;
	// Address word fields
	localparam int AW_CHAN_LSB = 0;
	localparam int AW_GRP_LSB = 7;
	localparam int AW_RNG_LSB = 10;
	localparam int AW_PAR = 13;
	localparam logic [2:0] HL_GROUP = 3'h4;
	// Display word fields
	localparam int DW_SIGN = 10;
	localparam int DW_YEL = 11;
	localparam int DW_RED = 12;
	// Time control bits
	localparam int TC_START = 0;
	localparam int TC_STOP = 1;
	localparam int TC_CLEAR = 2;
	// Register byte offsets
	localparam logic [7:0] A_CHADDR = 8'h00;
	localparam logic [7:0] A_DATA = 8'h04;
	localparam logic [7:0] A_SCAN = 8'h08;
	localparam logic [7:0] A_TCTRL = 8'h0C;
	localparam logic [7:0] A_TIME = 8'h10;
	localparam logic [7:0] A_DISP0 = 8'h14;
	localparam logic [7:0] A_RELAY = 8'h24;
	localparam logic [7:0] A_RSET = 8'h28;
	localparam logic [7:0] A_RCLR = 8'h2C;
	localparam logic [7:0] A_EV0 = 8'h30;
	localparam logic [7:0] A_WDOG = 8'h3C;
	// Reset values
	localparam logic [1:0] SCAN_RST = 2'h0;
	localparam logic [23:0] RELAY_RST = 24'h000000;
	// Conversion sequencer states
	typedef enum logic [1:0] {
		TDIO_IDLE = 2'b00,
		TDIO_PACE = 2'b01,
		TDIO_CONV = 2'b10
	} tdio_dg_t;
endpackage : tdio_pkg

//--- hdl/tdio_top.sv
// Test data I/O subsystems: digitizer control, clock, displays, relays, events, watchdog
//
// Decided for this implementation: the address-and-strobe port and the register offsets.
`timescale 1ns/10ps
// Notes on behaviour
// [R01] Host owns sixteen interrupt lines and four channels; three serve this block.
// [R02] Watchdog fails unless kicked at least every 10 ms.
// [R03] Each channel address written yields its converted data word back; the code drops a word written while a conversion is in progress.
// [R04] Address words are parity checked; a failure raises an interrupt.
// [R05] Host checks parity of returned data words itself.
// [R06] Four low-level groups of up to 96 channels, any order.
// [R07] Low-level range select: 10, 30, 100, 300, 500 mV bipolar.
// [R08] High-level multiplexer holds 100 channels plus 28 spare.
// [R09] Data word is 14-bit magnitude, sign, parity.
// [R10] No more than 10,000 conversions per second overall.
// [R11] Clock pulses go out as interrupt lines.
// [R12] Scan rate 1000, 500, 100 or 50 per second; fixed 1 pps display tick.
// [R13] Time accumulator returns a 24-bit word on read.
// [R14] Millisecond accumulator with start, stop and reset controls.
// [R15] Four displays: signed 000-999 with yellow and red lights.
// [R16] Display word: sign, 10-bit magnitude, two limit bits.
// [R17] One shared binary-to-decimal converter, under 100 us per word.
// [R18] Each finished display conversion pulses a completion interrupt.
// [R19] 24-bit relay word, one sets, zero resets, any combination.
// [R20] 72 event inputs raise interrupts on any change.
// [R21] Three 24-bit event groups, each with its own interrupt line.
// [R22] Host reads group state and time upon an event interrupt.
// [R23] Each group compares sample with latch each cycle, one-cycle pulse.
// [R24] Accumulator counts one per ms while started, wraps at all ones.
module tdio_top #(
	parameter int WDOG_CYCLES = tdio_pkg::WDOG_CYC
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	output logic [2:0] mux_grp_o,
	output logic [6:0] mux_chan_o,
	output logic [2:0] range_o,
	output logic adc_start_o,
	input wire logic adc_done_i,
	input wire logic adc_sign_i,
	input wire logic [13:0] adc_mag_i,
	output logic [15:0] data_o,
	output logic data_valid_o,
	output logic addr_err_irq_o,
	output logic scan_irq_o,
	output logic pps_irq_o,
	output logic [47:0] disp_bcd_o,
	output logic [3:0] disp_sign_o,
	output logic [3:0] disp_yel_o,
	output logic [3:0] disp_red_o,
	output logic disp_done_irq_o,
	output logic [23:0] relay_o,
	input wire logic [71:0] event_i,
	output logic [2:0] event_irq_o,
	output logic wdog_fail_o
);
	// Odd parity over a word, used on address words in and data words out
	function automatic logic odd_par(input logic [15:0] w);
		odd_par = ~^w;
	endfunction : odd_par
	// Write decode shared by every register except the display words, which use their own range decode
	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction : hit
	// Lowest set bit of the pending mask
	function automatic logic [1:0] pend_low(input logic [3:0] p);
		pend_low = p[0] ? 2'h0 : p[1] ? 2'h1 : p[2] ? 2'h2 : 2'h3;
	endfunction : pend_low
	// Pin synchronisers: first stage feeds only the second
	logic [71:0] ev_s1;
	logic [71:0] ev_s2;
	logic [14:0] adc_s1;
	logic [14:0] adc_s2;
	logic done_s1;
	logic done_s2;
	always_ff @(posedge clk_i) begin
		ev_s1 <= event_i;
		ev_s2 <= ev_s1;
		adc_s1 <= {adc_sign_i, adc_mag_i};
		adc_s2 <= adc_s1;
		done_s1 <= adc_done_i;
		done_s2 <= done_s1;
	end
	// Watchdog: each kick write restarts the window; failure holds until kicked
	logic [31:0] wd_cnt;
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			wd_cnt <= 32'h00000000;
			wdog_fail_o <= 1'b0;
		end else if (wr_i && hit(addr_i, tdio_pkg::A_WDOG)) begin
			wd_cnt <= 32'h00000000; // [R02]
			wdog_fail_o <= 1'b0;
		end else if (wd_cnt >= 32'(WDOG_CYCLES - 1)) begin
			wdog_fail_o <= 1'b1; // [R02]
		end else begin
			wd_cnt <= wd_cnt + 32'h00000001;
		end
	end
	// Time base: 1 us tick from the system clock, then 1 ms and 1 s ticks
	logic [3:0] us_cnt;
	logic [9:0] ms_us;
	logic [9:0] s_ms;
	logic us_tick;
	logic ms_tick;
	assign us_tick = (us_cnt == 4'(tdio_pkg::US_CYC - 1));
	assign ms_tick = us_tick && (ms_us == 10'(tdio_pkg::MS_US - 1));
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			us_cnt <= 4'h0;
			ms_us <= 10'h000;
			s_ms <= 10'h000;
			pps_irq_o <= 1'b0;
		end else begin
			us_cnt <= us_tick ? 4'h0 : us_cnt + 4'h1;
			if (us_tick) begin
				ms_us <= ms_tick ? 10'h000 : ms_us + 10'h001;
			end
			pps_irq_o <= 1'b0;
			if (ms_tick) begin
				if (s_ms == 10'(tdio_pkg::PPS_MS - 1)) begin
					s_ms <= 10'h000;
					pps_irq_o <= 1'b1; // [R12] [R11]
				end else begin
					s_ms <= s_ms + 10'h001;
				end
			end
		end
	end
	// Scan pulse: period in ms chosen by software, 1, 2, 10 or 20
	logic [1:0] scan_sel;
	logic [4:0] scan_cnt;
	logic [4:0] scan_period;
	always_comb begin
		case (scan_sel)
			2'h0: scan_period = 5'h01;
			2'h1: scan_period = 5'h02;
			2'h2: scan_period = 5'h0A;
			2'h3: scan_period = 5'h14;
			default: scan_period = 5'h01;
		endcase
	end
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			scan_sel <= tdio_pkg::SCAN_RST;
		end else if (wr_i && hit(addr_i, tdio_pkg::A_SCAN)) begin
			scan_sel <= wdata_i[1:0]; // [R12]
		end
	end
	// A rate change applies at the next ms tick, so the period in progress can end early
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			scan_cnt <= 5'h00;
			scan_irq_o <= 1'b0;
		end else begin
			scan_irq_o <= 1'b0;
			if (ms_tick) begin
				if (scan_cnt >= scan_period - 5'h01) begin
					scan_cnt <= 5'h00;
					scan_irq_o <= 1'b1; // [R11] [R12]
				end else begin
					scan_cnt <= scan_cnt + 5'h01;
				end
			end
		end
	end
	// Millisecond accumulator; clear wins over counting, stop wins over start
	logic [23:0] time_acc;
	logic time_run;
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			time_acc <= 24'h000000;
			time_run <= 1'b0;
		end else begin
			if (wr_i && hit(addr_i, tdio_pkg::A_TCTRL)) begin
				if (wdata_i[tdio_pkg::TC_START]) begin
					time_run <= 1'b1; // [R14]
				end
				if (wdata_i[tdio_pkg::TC_STOP]) begin
					time_run <= 1'b0; // [R14]
				end
			end
			if (wr_i && hit(addr_i, tdio_pkg::A_TCTRL) && wdata_i[tdio_pkg::TC_CLEAR]) begin
				time_acc <= 24'h000000; // [R14]
			end else if (time_run && ms_tick) begin
				time_acc <= time_acc + 24'h000001; // [R24]
			end
		end
	end
	// Digitizer sequencer: check address, wait for pacing slot, convert, return word
	tdio_pkg::tdio_dg_t dg_state;
	logic [10:0] pace_cnt;
	logic addr_wr;
	logic addr_ok;
	logic par_err;
	logic range_err;
	logic overrun;
	logic [2:0] w_grp;
	logic [6:0] w_chan;
	assign addr_wr = wr_i && hit(addr_i, tdio_pkg::A_CHADDR);
	assign w_grp = wdata_i[tdio_pkg::AW_GRP_LSB +: 3];
	assign w_chan = wdata_i[tdio_pkg::AW_CHAN_LSB +: 7];
	// A good word has an odd count of ones, so the parity helper is high on failure
	assign par_err = odd_par({2'h0, wdata_i[13:0]}); // [R04]
	// Low-level groups stop at 96, the high-level mux spans all 128 slots
	assign addr_ok = !par_err && ((w_grp < 3'(tdio_pkg::LL_GROUPS)
		&& w_chan < 7'(tdio_pkg::LL_CHANS)) || w_grp == tdio_pkg::HL_GROUP); // [R06] [R08]
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			dg_state <= tdio_pkg::TDIO_IDLE;
			pace_cnt <= 11'h000;
			mux_grp_o <= 3'h0;
			mux_chan_o <= 7'h00;
			range_o <= 3'h0;
			adc_start_o <= 1'b0;
			data_o <= 16'h0000;
			data_valid_o <= 1'b0;
			addr_err_irq_o <= 1'b0;
			range_err <= 1'b0;
			overrun <= 1'b0;
		end else begin
			adc_start_o <= 1'b0;
			data_valid_o <= 1'b0;
			addr_err_irq_o <= 1'b0;
			if (pace_cnt != 11'h000) begin
				pace_cnt <= pace_cnt - 11'h001;
			end
			if (addr_wr) begin
				range_err <= !addr_ok;
				addr_err_irq_o <= !addr_ok; // [R04]
				// A word arriving while busy is dropped and flagged
				overrun <= (dg_state != tdio_pkg::TDIO_IDLE);
			end
			case (dg_state)
				tdio_pkg::TDIO_IDLE: begin
					if (addr_wr && addr_ok) begin
						mux_grp_o <= w_grp; // [R03] [R06]
						mux_chan_o <= w_chan;
						range_o <= wdata_i[tdio_pkg::AW_RNG_LSB +: 3]; // [R07]
						dg_state <= tdio_pkg::TDIO_PACE;
					end
				end
				tdio_pkg::TDIO_PACE: begin
					if (pace_cnt == 11'h000) begin
						adc_start_o <= 1'b1;
						pace_cnt <= 11'(tdio_pkg::CONV_CYC - 1); // [R10]
						dg_state <= tdio_pkg::TDIO_CONV;
					end
				end
				tdio_pkg::TDIO_CONV: begin
					if (done_s2) begin
						data_o <= {odd_par({1'b0, adc_s2}), adc_s2}; // [R09] [R05]
						data_valid_o <= 1'b1; // [R03]
						dg_state <= tdio_pkg::TDIO_IDLE;
					end
				end
				default: dg_state <= tdio_pkg::TDIO_IDLE;
			endcase
		end
	end
	// Display words and the shared converter; the converter serves the lowest pending unit
	logic [12:0] disp_word [tdio_pkg::DISPS];
	logic [3:0] pend;
	logic cv_busy;
	logic [1:0] cv_idx;
	logic [3:0] cv_step;
	logic [21:0] cv_sr;
	logic [11:0] dab;
	logic [1:0] wr_disp;
	logic wr_disp_hit;
	assign wr_disp_hit = wr_i && addr_i >= tdio_pkg::A_DISP0
		&& addr_i < tdio_pkg::A_DISP0 + 8'h10 && addr_i[1:0] == 2'h0;
	assign wr_disp = 2'((addr_i - tdio_pkg::A_DISP0) >> 2);
	// Add-3 correction on each BCD digit before the shift
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			dab[4*i +: 4] = (cv_sr[10 + 4*i +: 4] >= 4'h5) ?
				cv_sr[10 + 4*i +: 4] + 4'h3 : cv_sr[10 + 4*i +: 4];
		end
	end
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			for (int i = 0; i < tdio_pkg::DISPS; i++) begin
				disp_word[i] <= 13'h0000;
			end
		end else if (wr_disp_hit) begin
			disp_word[wr_disp] <= wdata_i[12:0]; // [R16]
		end
	end
	// A new write sets pending even in the cycle the converter takes that unit
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			pend <= 4'h0;
			cv_busy <= 1'b0;
			cv_idx <= 2'h0;
			cv_step <= 4'h0;
			cv_sr <= 22'h000000;
			disp_bcd_o <= 48'h000000000000;
			disp_sign_o <= 4'h0;
			disp_yel_o <= 4'h0;
			disp_red_o <= 4'h0;
			disp_done_irq_o <= 1'b0;
		end else begin
			disp_done_irq_o <= 1'b0;
			if (!cv_busy) begin
				for (int i = tdio_pkg::DISPS - 1; i >= 0; i--) begin
					if (pend[i]) begin
						cv_idx <= 2'(i);
					end
				end
				if (pend != 4'h0) begin
					cv_busy <= 1'b1; // [R17]
					cv_step <= 4'h0;
				end
			end
			if (!cv_busy && pend != 4'h0) begin
				cv_sr <= 22'h000000;
			end else if (cv_busy && cv_step == 4'h0 && cv_sr == 22'h000000) begin
				// Load stage: clamp to the three-digit span
				cv_sr[9:0] <= (disp_word[cv_idx][9:0] > tdio_pkg::DISP_MAX) ?
					tdio_pkg::DISP_MAX : disp_word[cv_idx][9:0]; // [R15]
				cv_step <= 4'h1;
			end else if (cv_busy && cv_step != 4'h0) begin
				cv_sr <= {dab[10:0], cv_sr[9:0], 1'b0};
				if (cv_step == 4'(tdio_pkg::DMAG_W)) begin
					disp_bcd_o[12*cv_idx +: 12] <= {dab[10:0], cv_sr[9]}; // [R15]
					disp_sign_o[cv_idx] <= disp_word[cv_idx][tdio_pkg::DW_SIGN];
					disp_yel_o[cv_idx] <= disp_word[cv_idx][tdio_pkg::DW_YEL];
					disp_red_o[cv_idx] <= disp_word[cv_idx][tdio_pkg::DW_RED];
					disp_done_irq_o <= 1'b1; // [R18]
					cv_busy <= 1'b0;
					cv_step <= 4'h0;
				end else begin
					cv_step <= cv_step + 4'h1;
				end
			end
			for (int i = 0; i < tdio_pkg::DISPS; i++) begin
				if (wr_disp_hit && wr_disp == 2'(i)) begin
					pend[i] <= 1'b1;
				end else if (!cv_busy && pend != 4'h0 && pend_low(pend) == 2'(i)) begin
					pend[i] <= 1'b0;
				end
			end
		end
	end

	// Relays: whole word, or set and clear masks for single or grouped control
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			relay_o <= tdio_pkg::RELAY_RST;
		end else if (wr_i && hit(addr_i, tdio_pkg::A_RELAY)) begin
			relay_o <= wdata_i[23:0]; // [R19]
		end else if (wr_i && hit(addr_i, tdio_pkg::A_RSET)) begin
			relay_o <= relay_o | wdata_i[23:0]; // [R19]
		end else if (wr_i && hit(addr_i, tdio_pkg::A_RCLR)) begin
			relay_o <= relay_o & ~wdata_i[23:0]; // [R19]
		end
	end

	// Event groups: latch follows the synchronised inputs, any difference pulses the line
	logic [23:0] ev_latch [tdio_pkg::EV_GROUPS];
	genvar g;
	generate
		for (g = 0; g < tdio_pkg::EV_GROUPS; g++) begin : g_ev
			always_ff @(posedge clk_i) begin
				if (!rst_b_i) begin
					ev_latch[g] <= 24'h000000;
					event_irq_o[g] <= 1'b0;
				end else begin
					ev_latch[g] <= ev_s2[24*g +: 24]; // [R21] [R23]
					event_irq_o[g] <= (ev_s2[24*g +: 24] != ev_latch[g]); // [R20] [R23]
				end
			end
		end
	endgenerate

	// Read port: data stands in the cycle after the strobe; unmapped reads give zero
	always_ff @(posedge clk_i) begin
		if (!rst_b_i || !rd_i) begin
			rdata_o <= 32'h00000000;
		end else begin
			case (addr_i)
				tdio_pkg::A_CHADDR: rdata_o <= {28'h0000000, overrun, range_err,
					dg_state != tdio_pkg::TDIO_IDLE, wdog_fail_o};
				tdio_pkg::A_DATA: rdata_o <= {16'h0000, data_o};
				tdio_pkg::A_SCAN: rdata_o <= {30'h00000000, scan_sel};
				tdio_pkg::A_TCTRL: rdata_o <= {31'h00000000, time_run};
				tdio_pkg::A_TIME: rdata_o <= {8'h00, time_acc}; // [R13]
				tdio_pkg::A_RELAY: rdata_o <= {8'h00, relay_o};
				tdio_pkg::A_EV0: rdata_o <= {8'h00, ev_latch[0]}; // [R22]
				tdio_pkg::A_EV0 + 8'h04: rdata_o <= {8'h00, ev_latch[1]};
				tdio_pkg::A_EV0 + 8'h08: rdata_o <= {8'h00, ev_latch[2]};
				tdio_pkg::A_WDOG: rdata_o <= {31'h00000000, wdog_fail_o};
				default: rdata_o <= 32'h00000000;
			endcase
		end
	end
endmodule : tdio_top

//--- tb/tdio_top_properties.sv
// Port checks for the test data I/O block
`timescale 1ns/10ps
module tdio_checker #(
	parameter int WDOG_CYCLES = 100000
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic adc_start_o,
	input wire logic adc_done_i,
	input wire logic adc_sign_i,
	input wire logic [13:0] adc_mag_i,
	input wire logic [15:0] data_o,
	input wire logic data_valid_o,
	input wire logic addr_err_irq_o,
	input wire logic scan_irq_o,
	input wire logic disp_done_irq_o,
	input wire logic [23:0] relay_o,
	input wire logic wdog_fail_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	logic [10:0] since_start;
	logic [31:0] since_kick;
	wire logic kick = wr_i && addr_i == tdio_pkg::A_WDOG;
	// Cycles since last start; saturates so the first start after reset is free
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) since_start <= 11'h7FF;
		else if (adc_start_o) since_start <= 11'h001;
		else if (since_start != 11'h7FF) since_start <= since_start + 11'h001;
	end
	// Cycles since the last kick or reset
	always_ff @(posedge clk_i) begin
		if (!rst_b_i || kick) since_kick <= 32'h0;
		else since_kick <= since_kick + 32'h1;
	end
	property p_start_gap; adc_start_o |-> since_start >= 11'h3E8; endproperty
	a_start_gap: assert property (p_start_gap) else $error("starts too close");
	property p_valid_cause; data_valid_o |-> $past(adc_done_i, 2); endproperty
	a_valid_cause: assert property (p_valid_cause) else $error("valid without done");
	property p_fields; data_valid_o |-> data_o[14:0] == {$past(adc_sign_i, 2), $past(adc_mag_i, 2)};
	endproperty
	a_fields: assert property (p_fields) else $error("data word fields wrong");
	property p_parity; data_valid_o |-> ^data_o; endproperty
	a_parity: assert property (p_parity) else $error("data word parity wrong");
	property p_addr_err;
		wr_i && addr_i == tdio_pkg::A_CHADDR && !(^wdata_i[13:0]) |=> addr_err_irq_o ##1 !adc_start_o [*2];
	endproperty
	a_addr_err: assert property (p_addr_err) else $error("bad parity not refused");
	property p_relay; wr_i && addr_i == tdio_pkg::A_RELAY |=> relay_o == $past(wdata_i[23:0]); endproperty
	a_relay: assert property (p_relay) else $error("relay word not applied");
	property p_kick; kick |=> !wdog_fail_o; endproperty
	a_kick: assert property (p_kick) else $error("kick did not clear fail");
	property p_fail_time;
		$rose(wdog_fail_o) |-> since_kick >= WDOG_CYCLES - 3 && since_kick <= WDOG_CYCLES + 1;
	endproperty
	a_fail_time: assert property (p_fail_time) else $error("watchdog fail at wrong time");
	property p_disp; wr_i && addr_i == tdio_pkg::A_DISP0 |=> ##[0:1000] disp_done_irq_o; endproperty
	a_disp: assert property (p_disp) else $error("display conversion too slow");
	property p_scan; scan_irq_o |=> !scan_irq_o [*8]; endproperty
	a_scan: assert property (p_scan) else $error("scan pulses too close");
	c_conv: cover property (data_valid_o);
	c_err: cover property (addr_err_irq_o);
	c_fail: cover property ($rose(wdog_fail_o));
endmodule : tdio_checker

bind tdio_top tdio_checker #(.WDOG_CYCLES(WDOG_CYCLES)) i_tdio_checker (.clk_i, .rst_b_i,
	.addr_i, .wdata_i, .wr_i, .adc_start_o, .adc_done_i, .adc_sign_i, .adc_mag_i, .data_o,
	.data_valid_o, .addr_err_irq_o, .scan_irq_o, .disp_done_irq_o, .relay_o, .wdog_fail_o);

//--- tb/tdio_adc_model.sv
// Behavioural converter and multiplexer answering the digitizer control
`timescale 1ns/10ps
module tdio_adc_model (
	input wire logic clk_i,
	input wire logic start_i,
	input wire logic [2:0] grp_i,
	input wire logic [6:0] chan_i,
	input wire logic [2:0] rng_i,
	output logic done_o,
	output logic sign_o,
	output logic [13:0] mag_o
);
	initial begin
		done_o = 1'b0;
		sign_o = 1'b0;
		mag_o = 14'h0000;
	end
	// Odd channels answer slowly; released data lines show the inverse, not the old word
	always begin
		@(posedge clk_i);
		if (start_i === 1'b1) begin
			sign_o <= chan_i[0];
			mag_o <= {rng_i, grp_i, chan_i, 1'b1};
			repeat (chan_i[0] ? 40 : 2) @(posedge clk_i);
			done_o <= 1'b1;
			repeat (6) @(posedge clk_i);
			done_o <= 1'b0;
			sign_o <= ~sign_o;
			mag_o <= ~mag_o;
		end
	end
endmodule : tdio_adc_model

//--- tb/test_data_io_subsystems_test.sv
// Self-checking bench for the test data I/O block
`timescale 1ns/10ps
module test_data_io_subsystems_test;
	typedef struct packed {
		logic [2:0] grp;
		logic [6:0] chan;
		logic [2:0] rng;
		logic badpar;
		logic err;
	} tdio_row_t;
	logic clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic [7:0] addr_i = 8'h00;
	logic [31:0] wdata_i = 32'h0;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic [71:0] event_i = 72'h0;
	logic [31:0] rdata_o;
	logic [2:0] mux_grp_o, range_o, event_irq_o;
	logic [6:0] mux_chan_o;
	logic [13:0] adc_mag_i;
	logic [15:0] data_o;
	logic [47:0] disp_bcd_o;
	logic [3:0] disp_sign_o, disp_yel_o, disp_red_o;
	logic [23:0] relay_o;
	logic adc_start_o, adc_done_i, adc_sign_i, data_valid_o, addr_err_irq_o;
	logic scan_irq_o, pps_irq_o, disp_done_irq_o, wdog_fail_o;
	int err_total = 0;
	int n_compared = 0;
	int cyc = 0;
	int n_done = 0;
	// Rows mix prompt and slow answers, every range code, and three refusals
	tdio_row_t rows [8] = '{'{3'h0, 7'h00, 3'h0, 1'b0, 1'b0}, '{3'h3, 7'h5F, 3'h4, 1'b0, 1'b0},
		'{3'h4, 7'h7F, 3'h1, 1'b0, 1'b0}, '{3'h1, 7'h33, 3'h2, 1'b0, 1'b0},
		'{3'h2, 7'h02, 3'h3, 1'b0, 1'b0}, '{3'h0, 7'h60, 3'h0, 1'b0, 1'b1},
		'{3'h5, 7'h00, 3'h3, 1'b0, 1'b1}, '{3'h2, 7'h0A, 3'h3, 1'b1, 1'b1}};
	logic [12:0] dw [4] = '{13'h17E7, 13'h0BFF, 13'h0000, 13'h187B};

	tdio_top #(.WDOG_CYCLES(200)) i_tdio_top (.clk_i, .rst_b_i, .addr_i, .wdata_i, .wr_i, .rd_i,
		.rdata_o, .mux_grp_o, .mux_chan_o, .range_o, .adc_start_o, .adc_done_i, .adc_sign_i,
		.adc_mag_i, .data_o, .data_valid_o, .addr_err_irq_o, .scan_irq_o, .pps_irq_o, .disp_bcd_o,
		.disp_sign_o, .disp_yel_o, .disp_red_o, .disp_done_irq_o, .relay_o, .event_i, .event_irq_o,
		.wdog_fail_o);
	tdio_adc_model i_tdio_adc_model (.clk_i, .start_i(adc_start_o), .grp_i(mux_grp_o),
		.chan_i(mux_chan_o), .rng_i(range_o), .done_o(adc_done_i), .sign_o(adc_sign_i),
		.mag_o(adc_mag_i));

	// Clock, cycle count and display completion count
	always #50 clk_i = ~clk_i;
	always @(posedge clk_i) cyc++;
	always @(posedge clk_i) if (disp_done_irq_o === 1'b1) n_done++;

	task complete_run();
		$display("compared %0d mismatched %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : complete_run
	task chk_v(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			err_total++;
			$display("FAIL %s expected %h seen %h", nm, e, g);
		end
	endtask : chk_v
	task chk_f(input string nm, input logic e, input logic g);
		n_compared++;
		if (g !== e) begin
			err_total++;
			$display("FAIL %s expected %b seen %b", nm, e, g);
		end
	endtask : chk_f
	task tick();
		@(posedge clk_i);
		#1;
	endtask : tick
	// Bus cycles end 1 ns after the taking edge, so results are settled when looked at
	task bus_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge clk_i);
		wr_i <= 1'b0;
		#1;
	endtask : bus_wr
	task bus_rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1;
		d = rdata_o;
	endtask : bus_rd
	task wait_ev();
		int k;
		k = 0;
		while (event_irq_o === 3'b000 && k < 8) begin
			tick();
			k++;
		end
	endtask : wait_ev
	// Waits for one scan pulse, then counts the cycles to the next
	task scan_gap(output int n);
		int k;
		k = 0;
		while (scan_irq_o !== 1'b1 && k < 25000) begin
			tick();
			k++;
		end
		tick();
		n = 1;
		while (scan_irq_o !== 1'b1 && n < 25000) begin
			tick();
			n++;
		end
	endtask : scan_gap

	initial begin
		#9_500_000;
		err_total++;
		complete_run();
	end

	initial begin
		tdio_row_t r;
		logic [13:0] aw;
		logic [15:0] ex;
		logic [31:0] d, t0;
		int k, c0, n;
		repeat (2) @(posedge clk_i);
		rst_b_i <= 1'b1;
		#1;
		chk_v("relay", 32'(tdio_pkg::RELAY_RST), 32'(relay_o));
		chk_f("pps", 1'b0, pps_irq_o);
		bus_rd(tdio_pkg::A_SCAN, d);
		chk_v("scan_rst", 32'(tdio_pkg::SCAN_RST), d);
		bus_rd(8'hFC, d);
		chk_v("unmapped", 32'h0, d);
		$display("test reset done");
		foreach (rows[i]) begin
			r = rows[i];
			aw = {1'b0, r.rng, r.grp, r.chan};
			aw[13] = ~^aw[12:0] ^ r.badpar;
			bus_wr(tdio_pkg::A_CHADDR, {18'h0, aw});
			k = 0;
			while (addr_err_irq_o !== 1'b1 && data_valid_o !== 1'b1 && k < 2000) begin
				tick();
				k++;
			end
			chk_f("addr_err", r.err, addr_err_irq_o);
			chk_f("valid", !r.err, data_valid_o);
			if (!r.err) begin
				ex[14:0] = {r.chan[0], r.rng, r.grp, r.chan, 1'b1};
				ex[15] = ~^ex[14:0];
				chk_v("data", 32'(ex), 32'(data_o));
				bus_rd(tdio_pkg::A_DATA, d);
				chk_v("data_rd", 32'(ex), d);
			end
		end
		// Last row was refused and the watchdog has long run out: error and fail bits set
		bus_rd(tdio_pkg::A_CHADDR, d);
		chk_v("status", 32'h5, d);
		$display("test digitizer done");
		bus_wr(tdio_pkg::A_RELAY, 32'hFF5A0F3C);
		chk_v("relay", 32'h005A0F3C, 32'(relay_o));
		bus_wr(tdio_pkg::A_RSET, 32'h00000081);
		bus_wr(tdio_pkg::A_RCLR, 32'h00500000);
		bus_rd(tdio_pkg::A_RELAY, d);
		chk_v("relay_rd", 32'h000A0FBD, d);
		$display("test relays done");
		foreach (dw[i]) bus_wr(tdio_pkg::A_DISP0 + 8'(4 * i), {19'h0, dw[i]});
		repeat (1000) tick();
		chk_v("disp_done", 32'h4, n_done);
		foreach (dw[i]) begin
			k = (dw[i][9:0] > tdio_pkg::DISP_MAX) ? 999 : int'(dw[i][9:0]);
			chk_v("bcd", {4'(k / 100), 4'(k / 10 % 10), 4'(k % 10)}, disp_bcd_o[12*i+:12]);
			chk_v("lamps", dw[i][12:10], {disp_red_o[i], disp_yel_o[i], disp_sign_o[i]});
		end
		$display("test displays done");
		@(posedge clk_i);
		event_i[29] <= 1'b1;
		wait_ev();
		chk_v("ev_irq", 32'h2, 32'(event_irq_o));
		tick();
		chk_v("ev_irq", 32'h0, 32'(event_irq_o));
		bus_rd(tdio_pkg::A_EV0 + 8'h04, d);
		chk_v("ev_reg", 32'h00000020, d);
		@(posedge clk_i);
		event_i[3] <= 1'b1;
		event_i[71] <= 1'b1;
		wait_ev();
		chk_v("ev_irq", 32'h5, 32'(event_irq_o));
		$display("test events done");
		bus_wr(tdio_pkg::A_WDOG, 32'h0);
		repeat (150) tick();
		chk_f("wdog", 1'b0, wdog_fail_o);
		repeat (100) tick();
		chk_f("wdog", 1'b1, wdog_fail_o);
		bus_rd(tdio_pkg::A_WDOG, d);
		chk_v("wdog_rd", 32'h1, d);
		bus_wr(tdio_pkg::A_WDOG, 32'h0);
		chk_f("wdog", 1'b0, wdog_fail_o);
		$display("test watchdog done");
		for (k = 3; k >= 0; k--) begin
			bus_wr(tdio_pkg::A_SCAN, 32'(k));
			bus_rd(tdio_pkg::A_SCAN, d);
			chk_v("scan_sel", 32'(k), d);
		end
		bus_wr(tdio_pkg::A_TCTRL, 32'h4);
		bus_rd(tdio_pkg::A_TIME, d);
		chk_v("time_clr", 32'h0, d);
		bus_wr(tdio_pkg::A_TCTRL, 32'h1);
		scan_gap(n);
		chk_v("scan_gap", 32'h2710, n);
		bus_rd(tdio_pkg::A_TIME, t0);
		c0 = cyc;
		bus_wr(tdio_pkg::A_SCAN, 32'h1);
		scan_gap(n);
		chk_v("scan_gap", 32'h4E20, n);
		bus_rd(tdio_pkg::A_TIME, d);
		chk_v("time", t0 + 32'((cyc - c0) / 10000), d);
		bus_wr(tdio_pkg::A_TCTRL, 32'h2);
		bus_rd(tdio_pkg::A_TIME, t0);
		repeat (10100) tick();
		bus_rd(tdio_pkg::A_TIME, d);
		chk_v("time_stop", t0, d);
		$display("test clock done");
		complete_run();
	end
endmodule : test_data_io_subsystems_test
